// ==== src/ims_master.sv ====
// two-wire master sequencer: start, repeated start, stop, transmit,
// receive and acknowledge sequences behind a strobed register port
// assumes external pull-ups; SDA and SCL are open drain, low while oe is high
module ims_master
    import ims_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe
);
    ims_regs_s r;
    ims_regs_s next_r;

    function automatic logic cmd_busy(input logic [6:0] c);
        return |c[B_ACKSEQ:B_START];
    endfunction

    logic tick;
    logic idle_free;
    assign tick = (r.cnt == 8'h00);
    assign idle_free = (r.st == ST_IDLE) && !cmd_busy(r.ctrl) && r.en;

    always_comb begin
        next_r = r;
        next_r.sda_m = sda_in;
        next_r.sda_s = r.sda_m;
        next_r.scl_m = scl_in;
        next_r.scl_s = r.scl_m;
        if (!tick) begin
            next_r.cnt = r.cnt - 8'h01;
        end

        // register writes
        if (wr && addr == ADDR_CTRL2) begin
            next_r.ctrl[B_ACKDATA] = wdata[B_ACKDATA];
            if (idle_free) begin
                next_r.ctrl[B_ACKSEQ:B_START] = wdata[B_ACKSEQ:B_START];
            end
        end else if (wr && addr == ADDR_STATUS) begin
            next_r.en = wdata[S_EN];
            if (wdata[S_EVENT]) next_r.sef = 1'b0;
            if (wdata[S_BCOL]) next_r.bcf = 1'b0;
            if (wdata[S_WRITE_COLLISION_FLAG]) next_r.wcf = 1'b0;
        end else if (wr && addr == ADDR_BAUD) begin
            next_r.baud = wdata;
        end else if (wr && addr == ADDR_XFER) begin
            if (idle_free) begin
                next_r.xbuf = wdata;
                next_r.shreg = wdata;
                next_r.bf = 1'b1;
                next_r.bitc = 4'h0;
                next_r.cnt = r.baud;
                next_r.scl_oe = 1'b1;
                next_r.st = ST_TXL;
            end else begin
                next_r.wcf = 1'b1;
            end
        end

        // register reads, data one cycle later
        next_r.rdata = 8'h00;
        if (rd) begin
            if (addr == ADDR_CTRL2) begin
                next_r.rdata = {1'b0, r.ctrl};
            end else if (addr == ADDR_STATUS) begin
                next_r.rdata = {1'b0, r.en, r.wcf, r.bcf, r.sef, r.ps, r.ss, r.bf};
            end else if (addr == ADDR_BAUD) begin
                next_r.rdata = r.baud;
            end else begin
                next_r.rdata = r.xbuf;
                next_r.bf = 1'b0;
            end
        end

        case (r.st)
            ST_IDLE: begin
                if (r.ctrl[B_START]) begin
                    if (r.sda_s && r.scl_s) begin
                        next_r.cnt = r.baud;
                        next_r.st = ST_SWAIT;
                    end else begin
                        next_r.bcf = 1'b1;
                        next_r.ctrl[B_START] = 1'b0;
                    end
                end else if (r.ctrl[B_RESTART]) begin
                    next_r.scl_oe = 1'b1;
                    next_r.cnt = r.baud;
                    next_r.st = ST_RS1;
                end else if (r.ctrl[B_STOP]) begin
                    next_r.sda_oe = 1'b1;
                    next_r.cnt = r.baud;
                    next_r.st = ST_SP1;
                end else if (r.ctrl[B_RECV]) begin
                    next_r.sda_oe = 1'b0;
                    next_r.scl_oe = 1'b1;
                    next_r.bitc = 4'h0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_RXL;
                end else if (r.ctrl[B_ACKSEQ]) begin
                    next_r.scl_oe = 1'b1;
                    next_r.sda_oe = !r.ctrl[B_ACKDATA];
                    next_r.cnt = r.baud;
                    next_r.st = ST_AKL;
                end
            end
            ST_SWAIT: begin
                if (!r.scl_s || !r.sda_s) begin
                    next_r.bcf = 1'b1;
                    next_r.ctrl[B_START] = 1'b0;
                    next_r.st = ST_IDLE;
                end else if (tick) begin
                    next_r.sda_oe = 1'b1;
                    next_r.ss = 1'b1;
                    next_r.ps = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_SHOLD;
                end
            end
            ST_SHOLD: begin
                if (tick) begin
                    next_r.ctrl[B_START] = 1'b0;
                    next_r.sef = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            ST_RS1: begin
                next_r.sda_oe = 1'b0;
                if (r.scl_s) begin
                    next_r.cnt = r.baud;
                end else if (tick) begin
                    if (r.sda_s) begin
                        next_r.scl_oe = 1'b0;
                        next_r.hi_seen = 1'b0;
                        next_r.cnt = r.baud;
                        next_r.st = ST_RS2;
                    end else begin
                        next_r.bcf = 1'b1;
                        next_r.scl_oe = 1'b0;
                        next_r.ctrl[B_RESTART] = 1'b0;
                        next_r.st = ST_IDLE;
                    end
                end
            end
            ST_RS2: begin
                if (!r.scl_s && !r.hi_seen) begin
                    next_r.cnt = r.baud;
                end else if (!r.scl_s || !r.sda_s) begin
                    next_r.bcf = 1'b1;
                    next_r.scl_oe = 1'b0;
                    next_r.ctrl[B_RESTART] = 1'b0;
                    next_r.st = ST_IDLE;
                end else begin
                    next_r.hi_seen = 1'b1;
                    if (!r.hi_seen) begin
                        next_r.cnt = r.baud;
                    end else if (tick) begin
                        next_r.sda_oe = 1'b1;
                        next_r.ss = 1'b1;
                        next_r.ps = 1'b0;
                        next_r.cnt = r.baud;
                        next_r.st = ST_RS3;
                    end
                end
            end
            ST_RS3: begin
                if (tick) begin
                    next_r.scl_oe = 1'b1;
                    next_r.ctrl[B_RESTART] = 1'b0;
                    next_r.sef = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            ST_TXL: begin
                next_r.sda_oe = (r.bitc < BIT_ACK) ? !r.shreg[7] : 1'b0;
                if (tick) begin
                    next_r.scl_oe = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_TXH;
                end
            end
            ST_TXH: begin
                if (!r.scl_s) begin
                    next_r.cnt = r.baud;
                end else if (r.bitc < BIT_ACK && r.shreg[7] && !r.sda_s) begin
                    next_r.bcf = 1'b1;
                    next_r.bf = 1'b0;
                    next_r.sda_oe = 1'b0;
                    next_r.st = ST_IDLE;
                end else if (tick) begin
                    next_r.scl_oe = 1'b1;
                    if (r.bitc == BIT_ACK) begin
                        next_r.ctrl[B_ACK_STATUS] = r.sda_s;
                        next_r.sef = 1'b1;
                        next_r.st = ST_IDLE;
                    end else begin
                        if (r.bitc == BIT_LAST) next_r.bf = 1'b0;
                        next_r.bitc = r.bitc + 4'h1;
                        next_r.shreg = {r.shreg[6:0], 1'b0};
                        next_r.cnt = r.baud;
                        next_r.st = ST_TXL;
                    end
                end
            end
            ST_RXL: begin
                if (tick) begin
                    next_r.scl_oe = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_RXH;
                end
            end
            ST_RXH: begin
                if (!r.scl_s) begin
                    next_r.cnt = r.baud;
                end else if (tick) begin
                    next_r.scl_oe = 1'b1;
                    next_r.shreg = {r.shreg[6:0], r.sda_s};
                    next_r.bitc = r.bitc + 4'h1;
                    next_r.cnt = r.baud;
                    next_r.st = ST_RXL;
                    if (r.bitc == BIT_LAST) begin
                        next_r.xbuf = {r.shreg[6:0], r.sda_s};
                        next_r.bf = 1'b1;
                        next_r.sef = 1'b1;
                        next_r.ctrl[B_RECV] = 1'b0;
                        next_r.st = ST_IDLE;
                    end
                end
            end
            ST_AKL: begin
                if (tick) begin
                    next_r.scl_oe = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_AKH;
                end
            end
            ST_AKH: begin
                if (!r.scl_s) begin
                    next_r.cnt = r.baud;
                end else if (tick) begin
                    next_r.scl_oe = 1'b1;
                    next_r.ctrl[B_ACKSEQ] = 1'b0;
                    next_r.sef = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            ST_SP1: begin
                if (r.sda_s) begin
                    next_r.cnt = r.baud;
                end else if (tick) begin
                    next_r.scl_oe = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_SP2;
                end
            end
            ST_SP2: begin
                if (!r.scl_s) begin
                    next_r.cnt = r.baud;
                end else if (tick) begin
                    next_r.sda_oe = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = ST_SP3;
                end
            end
            ST_SP3: begin
                if (!r.sda_s || !r.scl_s) begin
                    next_r.cnt = r.baud;
                end else begin
                    next_r.ps = 1'b1;
                    next_r.ss = 1'b0;
                    if (tick) begin
                        next_r.ctrl[B_STOP] = 1'b0;
                        next_r.sef = 1'b1;
                        next_r.st = ST_IDLE;
                    end
                end
            end
            default: next_r.st = ST_IDLE;
        endcase

        // disable or collision returns to idle with lines released
        if (!r.en) begin
            next_r.st = ST_IDLE;
            next_r.ctrl[B_ACKSEQ:B_START] = 5'h00;
            next_r.sda_oe = 1'b0;
            next_r.scl_oe = 1'b0;
            next_r.ss = 1'b0;
            next_r.ps = 1'b0;
        end else if (next_r.bcf && !r.bcf) begin
            next_r.sda_oe = 1'b0;
            next_r.scl_oe = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.baud <= BAUD_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign sda_oe = r.sda_oe;
    assign scl_oe = r.scl_oe;
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_expire(ims_state_e s);
        r.st == s && r.cnt == 8'h00;
    endsequence

    property p_write_collision_flag;
        wr && addr == ADDR_XFER && r.st != ST_IDLE |=> r.wcf && $stable(r.xbuf);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write not dropped");

    property p_cmd_lock;
        wr && addr == ADDR_CTRL2 && r.ctrl[B_START] && r.st == ST_SWAIT
            |=> r.ctrl[B_ACKSEQ:B_RESTART] == $past(r.ctrl[B_ACKSEQ:B_RESTART]);
    endproperty
    a_cmd_lock: assert property (p_cmd_lock) else $error("command queued in start");

    property p_start_load;
        r.en && r.st == ST_IDLE && r.ctrl[B_START] && r.sda_s && r.scl_s
            |=> r.st == ST_SWAIT && r.cnt == r.baud;
    endproperty
    a_start_load: assert property (p_start_load) else $error("start not loaded");

    property p_start_fall;
        s_expire(ST_SWAIT) ##0 (r.sda_s && r.scl_s && r.en) |=> r.sda_oe && r.ss;
    endproperty
    a_start_fall: assert property (p_start_fall) else $error("start SDA not low");

    property p_start_col;
        r.en && r.st == ST_SWAIT && !r.scl_s |=> r.st == ST_IDLE && r.bcf;
    endproperty
    a_start_col: assert property (p_start_col) else $error("start collision missed");

    property p_tx_begin;
        wr && addr == ADDR_XFER && idle_free |=> r.bf && r.st == ST_TXL ##1 r.scl_oe;
    endproperty
    a_tx_begin: assert property (p_tx_begin) else $error("transmit not started");

    property p_sda_stable;
        r.st == ST_TXH && $past(r.st) == ST_TXH && !r.bcf |-> $stable(r.sda_oe);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("SDA moved in high");

    property p_ack_sample;
        s_expire(ST_TXH) ##0 (r.scl_s && r.bitc == BIT_ACK && r.en)
            |=> r.ctrl[B_ACK_STATUS] == $past(r.sda_s) && r.sef && r.scl_oe;
    endproperty
    a_ack_sample: assert property (p_ack_sample) else $error("ack not stored");

    property p_rx_done;
        s_expire(ST_RXH) ##0 (r.scl_s && r.bitc == BIT_LAST && r.en)
            |=> r.bf && r.sef && r.st == ST_IDLE && !r.ctrl[B_RECV] && r.scl_oe;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("receive end wrong");

    property p_rd_clear;
        rd && addr == ADDR_XFER && r.st != ST_RXH |=> !r.bf;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("full not cleared");
endmodule

// ==== src/ims_pkg.sv ====
// constants and types of the two-wire master sequencer
// assumes one 10 MHz system clock and a simple strobed register port
// Operation
// - buffer write while a sequence runs is dropped and sets write collision
// - command bits 4:0 cannot be written until a start completes
// - start with both lines high loads baud counter from reload value
// - at expiry with lines high drive SDA low, flag start; later finish start
// - lines low at start or SCL low early flags collision and aborts to idle
// - repeated start only taken when the sequencer is idle
// - repeated start pulls SCL low, releases SDA one period, then releases SCL
// - SCL high: both high one period, SDA low one period, then SCL low
// - start-seen set at SDA fall; event flag waits for counter expiry
// - repeated start collides if SDA low at SCL rise or SCL falls early
// - buffer write in idle sets buffer full and starts shifting
// - bit set after SCL falls; SCL low one period, high one period
// - after eighth clock clear buffer full and release SDA
// - acknowledge level at ninth clock stored in acknowledge status
// - after ninth clock raise event, hold SCL low until next buffer write or command
// - event flag raised when start, stop or repeated start completes
// - receive request ignored unless sequencer idle
// - receive toggles SCL on each rollover and shifts SDA in
// - after eighth received bit store byte, set full and event, go idle
// - reading the buffer after reception clears buffer full
// - after a received byte an acknowledge sequence may be requested
// - acknowledge sequence pulls SCL low and drives configured ack level
// - stop drives SDA low, then releases SCL, then SDA, by baud periods
package ims_pkg;
    localparam logic [1:0] ADDR_CTRL2 = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_BAUD = 2'h2;
    localparam logic [1:0] ADDR_XFER = 2'h3;
    // control_reg_two fields
    localparam int B_START = 0;
    localparam int B_RESTART = 1;
    localparam int B_STOP = 2;
    localparam int B_RECV = 3;
    localparam int B_ACKSEQ = 4;
    localparam int B_ACKDATA = 5;
    localparam int B_ACK_STATUS = 6;
    // status_reg fields
    localparam int S_FULL = 0;
    localparam int S_START = 1;
    localparam int S_STOP = 2;
    localparam int S_EVENT = 3;
    localparam int S_BCOL = 4;
    localparam int S_WRITE_COLLISION_FLAG = 5;
    localparam int S_EN = 6;
    localparam logic [7:0] BAUD_RESET = 8'h09;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00, ST_SWAIT = 5'h01, ST_SHOLD = 5'h02,
        ST_RS1 = 5'h03, ST_RS2 = 5'h04, ST_RS3 = 5'h05,
        ST_TXL = 5'h06, ST_TXH = 5'h07, ST_RXL = 5'h08, ST_RXH = 5'h09,
        ST_AKL = 5'h0A, ST_AKH = 5'h0B, ST_SP1 = 5'h0C, ST_SP2 = 5'h0D,
        ST_SP3 = 5'h0E
    } ims_state_e;

    typedef struct packed {
        ims_state_e st;
        logic [7:0] cnt;
        logic [3:0] bitc;
        logic [7:0] shreg;
        logic [7:0] xbuf;
        logic [7:0] baud;
        logic [6:0] ctrl;
        logic bf;
        logic ss;
        logic ps;
        logic sef;
        logic bcf;
        logic wcf;
        logic en;
        logic hi_seen;
        logic sda_oe;
        logic scl_oe;
        logic [7:0] rdata;
        logic sda_m;
        logic sda_s;
        logic scl_m;
        logic scl_s;
    } ims_regs_s;
endpackage

// ==== testbench/ims_slave_model.sv ====
// slave model on the two-wire bus: acks its address, queues written bytes,
// answers reads with a counting byte; assumes pull-ups on SDA and SCL
module ims_slave_model
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    parameter logic [7:0] TX_FIRST = 8'h3C
)
(
    input wire logic sda,
    input wire logic scl,
    input wire logic stretch,
    output logic sda_pull,
    output logic scl_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$];
    logic [7:0] tx_byte = TX_FIRST;
    logic [7:0] b;
    logic go_rd;
    int starts = 0;
    int stops = 0;
    event go;

    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
    end

    task automatic get_byte(output logic [7:0] x);
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            x[i] = sda;
        end
        @(negedge scl);
    endtask

    // ack in the ninth bit, slow answer holds SCL low a while
    task automatic ack_bit();
        sda_pull = 1'b1;
        if (stretch) begin
            scl_pull = 1'b1;
            #2000;
            scl_pull = 1'b0;
        end
        @(posedge scl);
        @(negedge scl);
        sda_pull = 1'b0;
    endtask

    always begin : body
        @(go);
        get_byte(b);
        if (b[7:1] == DEV_ADDR) begin
            ack_bit();
            if (b[0]) begin
                go_rd = 1'b1;
                while (go_rd) begin
                    for (int i = 7; i >= 0; i--) begin
                        sda_pull = ~tx_byte[i];
                        @(negedge scl);
                    end
                    sda_pull = 1'b0;
                    tx_byte = tx_byte + 8'h01;
                    @(posedge scl);
                    go_rd = ~sda;
                    @(negedge scl);
                end
            end else begin
                forever begin
                    get_byte(b);
                    rx_q.push_back(b);
                    ack_bit();
                end
            end
        end
    end

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            disable body;
            sda_pull = 1'b0;
            scl_pull = 1'b0;
            starts++;
            #1 -> go;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            disable body;
            sda_pull = 1'b0;
            scl_pull = 1'b0;
            stops++;
        end
    end
endmodule

// ==== testbench/tb_ims_master.sv ====
// self-checking bench of the two-wire master sequencer with a slave model
// assumes pulled-up SDA and SCL wires shared by design, model and bench
module tb_ims_master
    import ims_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] SLV_ADDR = 7'h2A;
    localparam logic [7:0] SLV_FIRST = 8'h3C;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic sda_oe;
    logic scl_oe;
    logic slv_sda;
    logic slv_scl;
    logic tb_sda = 1'b0;
    logic tb_scl = 1'b0;
    logic stretch = 1'b0;
    logic sda;
    logic scl;
    logic sda_out;
    logic scl_out;
    logic [7:0] v;
    logic [7:0] d;
    int seed = 70215;
    int err_count = 0;
    int num_checks = 0;
    int n0;

    assign sda = ~(sda_oe | slv_sda | tb_sda);
    assign scl = ~(scl_oe | slv_scl | tb_scl);
    always #50 clock = ~clock;

    ims_master DUT (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe)
    );
    ims_slave_model #(.DEV_ADDR(SLV_ADDR), .TX_FIRST(SLV_FIRST)) SLV (
        .sda(sda), .scl(scl), .stretch(stretch), .sda_pull(slv_sda), .scl_pull(slv_scl)
    );

    function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic rw);
        return {a, rw};
    endfunction
    function automatic logic [7:0] rx_exp(input int n);
        return SLV_FIRST + 8'(n);
    endfunction

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] x);
        @(posedge clock);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] x);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        x = rdata;
    endtask

    task automatic wait_flag(input int b);
        for (int i = 0; i < 3000; i++) begin
            rd_reg(ADDR_STATUS, v);
            if (v[b] === 1'b1) return;
        end
        check1("flag wait", 1'b1, 1'b0);
    endtask
    // wait for the event, then clear event and both collision flags
    task automatic step();
        wait_flag(S_EVENT);
        wr_reg(ADDR_STATUS, 8'h78);
    endtask

    task automatic send(input logic [7:0] x, input logic ak);
        wr_reg(ADDR_XFER, x);
        wr_reg(ADDR_XFER, ~x);
        rd_reg(ADDR_STATUS, v);
        check8("full and write_collision_flag", 8'h61, v & 8'h61);
        step();
        check1("scl held", 1'b0, scl);
        rd_reg(ADDR_STATUS, v);
        check1("full after byte", 1'b0, v[S_FULL]);
        rd_reg(ADDR_CTRL2, v);
        check1("ack status", ak, v[B_ACK_STATUS]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd_reg(ADDR_STATUS, v);
        check8("status reset", 8'h00, v);
        rd_reg(ADDR_BAUD, v);
        check8("baud reset", BAUD_RESET, v);
        wr_reg(ADDR_STATUS, 8'h40);
        // both lines low before start
        tb_sda <= 1'b1;
        @(posedge clock);
        tb_scl <= 1'b1;
        wr_reg(ADDR_CTRL2, 8'h01);
        wait_flag(S_BCOL);
        rd_reg(ADDR_CTRL2, v);
        check8("ctrl2 after collision", 8'h00, v & 8'h1F);
        check1("sda released", 1'b0, sda_oe);
        tb_scl <= 1'b0;
        @(posedge clock);
        tb_sda <= 1'b0;
        wr_reg(ADDR_STATUS, 8'h78);
        // SCL pulled low by another device while the start waits
        wr_reg(ADDR_CTRL2, 8'h01);
        tb_scl <= 1'b1;
        wait_flag(S_BCOL);
        rd_reg(ADDR_CTRL2, v);
        check8("ctrl2 after late collision", 8'h00, v & 8'h1F);
        tb_scl <= 1'b0;
        wr_reg(ADDR_STATUS, 8'h78);
        n0 = SLV.starts;
        wr_reg(ADDR_CTRL2, 8'h01);
        wr_reg(ADDR_CTRL2, 8'h1E);
        wr_reg(ADDR_XFER, 8'hA5);
        rd_reg(ADDR_CTRL2, v);
        check8("ctrl2 during start", 8'h01, v & 8'h1F);
        wait_flag(S_EVENT);
        rd_reg(ADDR_STATUS, v);
        check8("status after start", 8'h6A, v);
        check1("sda after start", 1'b0, sda);
        check1("scl after start", 1'b1, scl);
        check1("sda out level", 1'b0, sda_out);
        check1("scl out level", 1'b0, scl_out);
        check8("starts", 8'h01, 8'(SLV.starts - n0));
        rd_reg(ADDR_CTRL2, v);
        check8("ctrl2 after start", 8'h00, v & 8'h1F);
        wr_reg(ADDR_STATUS, 8'h78);
        wr_reg(ADDR_BAUD, 8'h02);
        send(addr_byte(SLV_ADDR, 1'b0), 1'b0);
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            stretch <= 1'($random(seed));
            send(d, 1'b0);
            check8("slave byte", d, SLV.rx_q.pop_front());
        end
        n0 = SLV.starts;
        wr_reg(ADDR_CTRL2, 8'h02);
        step();
        check8("restarts", 8'h01, 8'(SLV.starts - n0));
        rd_reg(ADDR_STATUS, v);
        check1("start seen", 1'b1, v[S_START]);
        send(addr_byte(SLV_ADDR, 1'b1), 1'b0);
        for (int k = 0; k < 3; k++) begin
            wr_reg(ADDR_CTRL2, 8'h08);
            step();
            rd_reg(ADDR_STATUS, v);
            check1("full after receive", 1'b1, v[S_FULL]);
            rd_reg(ADDR_XFER, v);
            check8("received byte", rx_exp(k), v);
            rd_reg(ADDR_STATUS, v);
            check1("full after read", 1'b0, v[S_FULL]);
            wr_reg(ADDR_CTRL2, (k == 2) ? 8'h30 : 8'h10);
            step();
        end
        n0 = SLV.stops;
        wr_reg(ADDR_CTRL2, 8'h04);
        step();
        rd_reg(ADDR_STATUS, v);
        check1("stop seen", 1'b1, v[S_STOP]);
        check1("start seen after stop", 1'b0, v[S_START]);
        check8("stops", 8'h01, 8'(SLV.stops - n0));
        check1("sda idle", 1'b1, sda);
        wr_reg(ADDR_CTRL2, 8'h01);
        step();
        rd_reg(ADDR_STATUS, v);
        check8("status after second start", 8'h42, v);
        send(addr_byte(~SLV_ADDR, 1'b0), 1'b1);
        wr_reg(ADDR_CTRL2, 8'h04);
        step();
        summarize();
    end
endmodule
